// File: pfs_pin_mux.sv
// function select for pins P0.5 to P1.3 with its register file
// assumes classic wishbone on clk_i and peripherals on the same clock
module pfs_pin_mux
   import pfs_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pads
   input wire logic [NUM_PINS-1:0] pad_i,
   output logic [NUM_PINS-1:0] pad_o,
   output logic [NUM_PINS-1:0] pad_oe_o,
   // pwm and buzzer sources
   input wire logic [PWM_CHANNELS-1:0] pwm_i,
   input wire logic buzzer_i,
   // i2c master and second slave, pull requests and received levels
   input wire logic i2c_m_scl_pull_i,
   input wire logic i2c_m_sda_pull_i,
   input wire logic i2c_s2_scl_pull_i,
   input wire logic i2c_s2_sda_pull_i,
   output logic i2c_m_scl_in_o,
   output logic i2c_m_sda_in_o,
   output logic i2c_s2_scl_in_o,
   output logic i2c_s2_sda_in_o,
   // spi controller
   input wire logic spi_sck_out_i,
   input wire logic spi_sck_oe_i,
   input wire logic spi_so_out_i,
   input wire logic spi_so_oe_i,
   input wire logic spi_mo_out_i,
   input wire logic spi_mo_oe_i,
   output logic spi_sck_in_o,
   output logic spi_so_in_o,
   output logic spi_mo_in_o,
   output logic spi_select_n_o,
   // uarts
   input wire logic uart_two_txd_i,
   input wire logic uart_zero_txd_i,
   output logic uart_two_rxd_o,
   output logic uart_zero_rxd_o,
   // capture modules 4 and 5
   input wire logic [1:0] cap_out_i,
   input wire logic [1:0] cap_oe_i,
   output logic [1:0] cap_in_o,
   // shared pin interrupt conditions
   output logic [NUM_PINS-1:0] irq_a_pins_o,
   output logic [NUM_PINS-1:0] irq_b_pins_o,
   // plain io
   input wire logic [NUM_PINS-1:0] gpio_out_i,
   input wire logic [NUM_PINS-1:0] gpio_oe_i,
   output logic [NUM_PINS-1:0] gpio_in_o
);

   logic [CFG_W-1:0] cfg_reg [NUM_PINS];
   logic [NUM_PINS-1:0] pad_sync;
   pfs_route_type route [NUM_PINS];
   logic [NUM_PINS-1:0] sel6, sel5, sel4, sel3, sel_gpio;
   logic [NUM_PINS-1:0] f6_o, f6_oe, f5_o, f5_oe, f4_o, f4_oe, f3_o, f3_oe;
   logic bus_req, bus_hit;
   logic [SLOT_W-1:0] bus_slot;

   // routing priority when software sets several bits at once
   function automatic pfs_route_type pick_route(input logic [CFG_W-1:0] cfg);
      if (cfg[BIT_PWM]) return RT_PWM;
      if (cfg[BIT_FN6]) return RT_FN6;
      if (cfg[BIT_FN5]) return RT_FN5;
      if (cfg[BIT_FN4]) return RT_FN4;
      if (cfg[BIT_FN3]) return RT_FN3;
      if (cfg[BIT_GPIO]) return RT_GPIO;
      return RT_NONE;
   endfunction

   function automatic logic adr_hit(input logic [ADR_W-1:0] adr);
      logic [IDX_W-1:0] idx;
      idx = adr[ADR_W-1:2];
      return (adr[1:0] == 2'h0) && (idx >= REG_FIRST_IDX) && (idx <= REG_LAST_IDX);
   endfunction

   function automatic logic [SLOT_W-1:0] adr_slot(input logic [ADR_W-1:0] adr);
      return SLOT_W'(adr[ADR_W-1:2] - REG_FIRST_IDX);
   endfunction

   // idle-high input fed by several pins: any selected pin low pulls it low
   function automatic logic all_high(input logic [NUM_PINS-1:0] en,
                                     input logic [NUM_PINS-1:0] lvl);
      return &(~en | lvl);
   endfunction

   // idle-low input fed by several pins
   function automatic logic any_high(input logic [NUM_PINS-1:0] en,
                                     input logic [NUM_PINS-1:0] lvl);
      return |(en & lvl);
   endfunction

   pfs_sync2 u_pad_sync (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .async_i(pad_i),
      .sync_o(pad_sync)
   );

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   assign bus_req = wb_cyc_i && wb_stb_i;
   assign bus_hit = adr_hit(wb_adr_i);
   assign bus_slot = adr_slot(wb_adr_i);

   // one wait state, ack drops the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
      end
   end

   // readback; unmapped addresses answer zero
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wb_dat_o <= '0;
      end else if (bus_req && !wb_ack_o && !wb_we_i && bus_hit) begin
         wb_dat_o <= 32'(cfg_reg[bus_slot]);
      end else begin
         wb_dat_o <= '0;
      end
   end

   // write commits at the edge where the master sees ack
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            cfg_reg[i] <= CFG_RESET;
         end
      end else if (bus_req && wb_ack_o && wb_we_i && wb_sel_i[0] && bus_hit) begin
         // bit 4 holds no function on four pins and stays zero there
         cfg_reg[bus_slot] <= wb_dat_i[CFG_W-1:0]
            & (PINS_FN4[bus_slot] ? CFG_ALL_BITS : CFG_NO_FN4);
      end
   end

   property p_ack_single;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");
   sequence s_write_p0_5;
      bus_req && wb_we_i && wb_ack_o && wb_sel_i[0]
         && wb_adr_i == ADR_W'({REG_P0_5_IDX, 2'h0});
   endsequence
   property p_write_stores;
      s_write_p0_5 |=> cfg_reg[PIN_P0_5] == ($past(wb_dat_i[CFG_W-1:0]) & CFG_NO_FN4);
   endproperty
   a_write_stores: assert property (p_write_stores) else $error("write lost");
   sequence s_read_p1_0;
      bus_req && !wb_we_i && !wb_ack_o && wb_adr_i == ADR_W'({REG_P1_0_IDX, 2'h0});
   endsequence
   property p_read_back;
      s_read_p1_0 |=> wb_ack_o && wb_dat_o == 32'($past(cfg_reg[PIN_P1_0]));
   endproperty
   a_read_back: assert property (p_read_back) else $error("bad readback");

   // route decode per pin
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         route[i] = pick_route(cfg_reg[i]);
         sel6[i] = route[i] == RT_FN6;
         sel5[i] = route[i] == RT_FN5;
         sel4[i] = route[i] == RT_FN4;
         sel3[i] = route[i] == RT_FN3;
         sel_gpio[i] = route[i] == RT_GPIO;
      end
   end

   // drive offered by each pin's functions; i2c is open drain, low only
   always_comb begin
      {f6_o, f6_oe, f5_o, f5_oe, f4_o, f4_oe, f3_o, f3_oe} = '0;
      for (int i = 0; i < NUM_PINS; i++) begin
         if (PINS_I2C_CLK[i]) begin
            f6_oe[i] = i2c_m_scl_pull_i;
            f5_oe[i] = i2c_s2_scl_pull_i;
         end
         if (PINS_I2C_DATA[i]) begin
            f6_oe[i] = i2c_m_sda_pull_i;
            f5_oe[i] = i2c_s2_sda_pull_i;
         end
         if (PINS_SPI_CLK[i]) begin
            f3_o[i] = spi_sck_out_i;
            f3_oe[i] = spi_sck_oe_i;
         end
         if (PINS_SPI_SO[i]) begin
            f3_o[i] = spi_so_out_i;
            f3_oe[i] = spi_so_oe_i;
         end
         if (PINS_SPI_MO[i]) begin
            f3_o[i] = spi_mo_out_i;
            f3_oe[i] = spi_mo_oe_i;
         end
      end
      // receive-only functions on P1.0 and spi select pins leave oe low
      f6_o[PIN_P1_1] = uart_two_txd_i;
      f6_oe[PIN_P1_1] = 1'b1;
      f5_o[PIN_P1_1] = uart_zero_txd_i;
      f5_oe[PIN_P1_1] = 1'b1;
      f4_o[PIN_P0_7] = buzzer_i;
      f4_oe[PIN_P0_7] = 1'b1;
      f4_o[PIN_P1_0] = cap_out_i[0];
      f4_oe[PIN_P1_0] = cap_oe_i[0];
      f4_o[PIN_P1_1] = cap_out_i[1];
      f4_oe[PIN_P1_1] = cap_oe_i[1];
   end

   // pad drivers, registered so the pads never see decode glitches
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pad_o <= '0;
         pad_oe_o <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            case (route[i])
               RT_PWM: begin
                  pad_o[i] <= pwm_i[PIN_PWM_CH[i]];
                  pad_oe_o[i] <= 1'b1;
               end
               RT_FN6: begin
                  pad_o[i] <= f6_o[i];
                  pad_oe_o[i] <= f6_oe[i];
               end
               RT_FN5: begin
                  pad_o[i] <= f5_o[i];
                  pad_oe_o[i] <= f5_oe[i];
               end
               RT_FN4: begin
                  pad_o[i] <= f4_o[i];
                  pad_oe_o[i] <= f4_oe[i];
               end
               RT_FN3: begin
                  pad_o[i] <= f3_o[i];
                  pad_oe_o[i] <= f3_oe[i];
               end
               RT_GPIO: begin
                  pad_o[i] <= gpio_out_i[i];
                  pad_oe_o[i] <= gpio_oe_i[i];
               end
               default: begin
                  pad_o[i] <= 1'b0;
                  pad_oe_o[i] <= 1'b0;
               end
            endcase
         end
      end
   end

   property p_pwm_p0_5;
      cfg_reg[PIN_P0_5][BIT_PWM] |=> pad_oe_o[PIN_P0_5] && pad_o[PIN_P0_5] == $past(pwm_i[11]);
   endproperty
   a_pwm_p0_5: assert property (p_pwm_p0_5) else $error("pwm 11 not on P0.5");
   property p_i2c_clk_p1_3;
      route[PIN_P1_3] == RT_FN6
         |=> !pad_o[PIN_P1_3] && pad_oe_o[PIN_P1_3] == $past(i2c_m_scl_pull_i);
   endproperty
   a_i2c_clk_p1_3: assert property (p_i2c_clk_p1_3) else $error("scl not open drain");
   property p_buzzer_p0_7;
      route[PIN_P0_7] == RT_FN4 |=> pad_oe_o[PIN_P0_7] && pad_o[PIN_P0_7] == $past(buzzer_i);
   endproperty
   a_buzzer_p0_7: assert property (p_buzzer_p0_7) else $error("buzzer not routed");
   property p_standard_uart_zero_tx;
      route[PIN_P1_1] == RT_FN5
         |=> pad_oe_o[PIN_P1_1] && pad_o[PIN_P1_1] == $past(uart_zero_txd_i);
   endproperty
   a_standard_uart_zero_tx: assert property (p_standard_uart_zero_tx) else $error("uart zero tx not routed");
   property p_idle_pin;
      cfg_reg[PIN_P1_2] == CFG_RESET [*2] |-> !pad_oe_o[PIN_P1_2];
   endproperty
   a_idle_pin: assert property (p_idle_pin) else $error("unselected pin driven");

   // peripheral inputs from synchronised pad levels, idle when unrouted
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         i2c_m_scl_in_o <= 1'b1;
         i2c_m_sda_in_o <= 1'b1;
         i2c_s2_scl_in_o <= 1'b1;
         i2c_s2_sda_in_o <= 1'b1;
         spi_sck_in_o <= 1'b0;
         spi_so_in_o <= 1'b0;
         spi_mo_in_o <= 1'b0;
         spi_select_n_o <= 1'b1;
         uart_two_rxd_o <= 1'b1;
         uart_zero_rxd_o <= 1'b1;
         cap_in_o <= '0;
      end else begin
         i2c_m_scl_in_o <= all_high(sel6 & PINS_I2C_CLK, pad_sync);
         i2c_m_sda_in_o <= all_high(sel6 & PINS_I2C_DATA, pad_sync);
         i2c_s2_scl_in_o <= all_high(sel5 & PINS_I2C_CLK, pad_sync);
         i2c_s2_sda_in_o <= all_high(sel5 & PINS_I2C_DATA, pad_sync);
         spi_sck_in_o <= any_high(sel3 & PINS_SPI_CLK, pad_sync);
         spi_so_in_o <= any_high(sel3 & PINS_SPI_SO, pad_sync);
         spi_mo_in_o <= any_high(sel3 & PINS_SPI_MO, pad_sync);
         spi_select_n_o <= all_high(sel3 & PINS_SPI_SEL, pad_sync);
         uart_two_rxd_o <= !sel6[PIN_P1_0] || pad_sync[PIN_P1_0];
         uart_zero_rxd_o <= !sel5[PIN_P1_0] || pad_sync[PIN_P1_0];
         cap_in_o[0] <= sel4[PIN_P1_0] && pad_sync[PIN_P1_0];
         cap_in_o[1] <= sel4[PIN_P1_1] && pad_sync[PIN_P1_1];
      end
   end

   // interrupt joins bypass the routing priority so a pin feeds both
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_a_pins_o <= '0;
         irq_b_pins_o <= '0;
         gpio_in_o <= '0;
      end else begin
         for (int i = 0; i < NUM_PINS; i++) begin
            irq_a_pins_o[i] <= cfg_reg[i][BIT_IRQ_A] && pad_sync[i];
            irq_b_pins_o[i] <= cfg_reg[i][BIT_IRQ_B] && pad_sync[i];
         end
         gpio_in_o <= sel_gpio & pad_sync;
      end
   end

   property p_standard_uart_zero_rx;
      route[PIN_P1_0] == RT_FN5 |=> uart_zero_rxd_o == $past(pad_sync[PIN_P1_0]);
   endproperty
   a_standard_uart_zero_rx: assert property (p_standard_uart_zero_rx) else $error("uart zero rx not fed");
   property p_spi_select;
      route[PIN_P1_3] == RT_FN3 && !pad_sync[PIN_P1_3] |=> !spi_select_n_o;
   endproperty
   a_spi_select: assert property (p_spi_select) else $error("select not fed");
   property p_irq_both;
      cfg_reg[PIN_P1_0][BIT_IRQ_A] && cfg_reg[PIN_P1_0][BIT_IRQ_B]
         |=> irq_a_pins_o[PIN_P1_0] == $past(pad_sync[PIN_P1_0])
            && irq_b_pins_o[PIN_P1_0] == $past(pad_sync[PIN_P1_0]);
   endproperty
   a_irq_both: assert property (p_irq_both) else $error("irq join broken");

endmodule

// File: pfs_pkg.sv
// constants and types shared by the pin function select block
// assumes a single 250 MHz clock and a classic wishbone register bus
package pfs_pkg;

   // pins handled here, index 0 is P0.5 up to index 6 for P1.3
   localparam int unsigned NUM_PINS = 7;
   localparam int unsigned PIN_P0_5 = 0;
   localparam int unsigned PIN_P0_6 = 1;
   localparam int unsigned PIN_P0_7 = 2;
   localparam int unsigned PIN_P1_0 = 3;
   localparam int unsigned PIN_P1_1 = 4;
   localparam int unsigned PIN_P1_2 = 5;
   localparam int unsigned PIN_P1_3 = 6;

   // configuration register layout
   localparam int unsigned CFG_W = 8;
   localparam int unsigned BIT_PWM = 7;
   localparam int unsigned BIT_FN6 = 6;
   localparam int unsigned BIT_FN5 = 5;
   localparam int unsigned BIT_FN4 = 4;
   localparam int unsigned BIT_FN3 = 3;
   localparam int unsigned BIT_IRQ_B = 2;
   localparam int unsigned BIT_IRQ_A = 1;
   localparam int unsigned BIT_GPIO = 0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_ALL_BITS = 8'hFF;
   localparam logic [7:0] CFG_NO_FN4 = 8'hEF;

   // register indices; byte address on the bus is four times the index
   localparam int unsigned ADR_W = 18;
   localparam int unsigned IDX_W = 16;
   localparam int unsigned SLOT_W = 3;
   localparam logic [15:0] REG_P0_5_IDX = 16'hA055;
   localparam logic [15:0] REG_P0_6_IDX = 16'hA056;
   localparam logic [15:0] REG_P0_7_IDX = 16'hA057;
   localparam logic [15:0] REG_P1_0_IDX = 16'hA058;
   localparam logic [15:0] REG_P1_1_IDX = 16'hA059;
   localparam logic [15:0] REG_P1_2_IDX = 16'hA05A;
   localparam logic [15:0] REG_P1_3_IDX = 16'hA05B;
   localparam logic [15:0] REG_FIRST_IDX = REG_P0_5_IDX;
   localparam logic [15:0] REG_LAST_IDX = REG_P1_3_IDX;

   // pwm channel wired to each pin, index order as the pins above
   localparam int unsigned PWM_CHANNELS = 12;
   localparam int unsigned PIN_PWM_CH [NUM_PINS] = '{11, 3, 4, 5, 6, 0, 1};

   // which pins carry which shared function
   localparam logic [6:0] PINS_I2C_CLK = 7'h45;
   localparam logic [6:0] PINS_I2C_DATA = 7'h22;
   localparam logic [6:0] PINS_SPI_CLK = 7'h05;
   localparam logic [6:0] PINS_SPI_SO = 7'h02;
   localparam logic [6:0] PINS_SPI_MO = 7'h28;
   localparam logic [6:0] PINS_SPI_SEL = 7'h50;
   localparam logic [6:0] PINS_FN4 = 7'h1C;

   // function picked for a pin after priority among routing bits
   typedef enum logic [2:0] {
      RT_NONE, RT_PWM, RT_FN6, RT_FN5, RT_FN4, RT_FN3, RT_GPIO
   } pfs_route_type;

endpackage

// File: pfs_sync2.sv
// two flip-flop synchroniser for the pad input levels
// assumes the pads are asynchronous to clk_i
module pfs_sync2
   import pfs_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // levels
   input wire logic [NUM_PINS-1:0] async_i,
   output logic [NUM_PINS-1:0] sync_o
);

   logic [NUM_PINS-1:0] meta_reg;

   // first stage is read only by the second stage
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_reg <= '0;
         sync_o <= '0;
      end else begin
         meta_reg <= async_i;
         sync_o <= meta_reg;
      end
   end

endmodule

// File: pfs_far_side.sv
// far side of the seven pads: board pull-ups and outside drivers
// assumes every pad has a board pull-up and outside drivers are ideal
module pfs_far_side
   import pfs_pkg::*;
(
   // design side of the pads
   input wire logic [NUM_PINS-1:0] pad_out_i,
   input wire logic [NUM_PINS-1:0] pad_oe_i,
   // outside drivers
   input wire logic [NUM_PINS-1:0] ext_val_i,
   input wire logic [NUM_PINS-1:0] ext_oe_i,
   // resolved pad levels
   output logic [NUM_PINS-1:0] pad_lvl_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // chip drive first, then outside drive, else the pull-up
   // open drain lines only pull low, so the pull-up gives their high level
   always_comb begin
      for (int p = 0; p < NUM_PINS; p++) begin
         if (pad_oe_i[p]) begin
            pad_lvl_o[p] = pad_out_i[p];
         end else if (ext_oe_i[p]) begin
            pad_lvl_o[p] = ext_val_i[p];
         end else begin
            pad_lvl_o[p] = 1'b1;
         end
      end
   end
endmodule

// File: tb_top.sv
// self-checking bench for the pin function select block
// assumes the package, the design and the far side model compile first
module tb_top
   import pfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // row kinds: chip drives, open drain, input only
   localparam logic [1:0] DRV = 2'h0;
   localparam logic [1:0] OD = 2'h1;
   localparam logic [1:0] INP = 2'h2;
   localparam logic [3:0] NO = 4'hF;
   typedef struct packed {
      logic [2:0] pin;
      logic [7:0] cfg;
      logic [1:0] kind;
      logic [3:0] idx;
   } pfs_row_type;

   // one routing bit per row, since priority among several is a design choice
   localparam pfs_row_type ROWS [37] = '{
      '{3'h0, 8'h80, DRV, NO}, '{3'h0, 8'h40, OD, 4'h0}, '{3'h0, 8'h20, OD, 4'h2},
      '{3'h0, 8'h08, DRV, 4'h4}, '{3'h0, 8'h04, INP, 4'hE}, '{3'h1, 8'h80, DRV, NO},
      '{3'h1, 8'h40, OD, 4'h1}, '{3'h1, 8'h20, OD, 4'h3}, '{3'h1, 8'h08, DRV, 4'h5},
      '{3'h1, 8'h02, INP, 4'hD}, '{3'h2, 8'h80, DRV, NO}, '{3'h2, 8'h40, OD, 4'h0},
      '{3'h2, 8'h20, OD, 4'h2}, '{3'h2, 8'h10, DRV, NO}, '{3'h2, 8'h08, DRV, 4'h4},
      '{3'h2, 8'h01, DRV, 4'hC}, '{3'h3, 8'h80, DRV, NO}, '{3'h3, 8'h40, INP, 4'h8},
      '{3'h3, 8'h20, INP, 4'h9}, '{3'h3, 8'h10, DRV, 4'hA}, '{3'h3, 8'h08, DRV, 4'h6},
      '{3'h3, 8'h01, DRV, 4'hC}, '{3'h4, 8'h80, DRV, NO}, '{3'h4, 8'h40, DRV, NO},
      '{3'h4, 8'h20, DRV, NO}, '{3'h4, 8'h10, DRV, 4'hB}, '{3'h4, 8'h08, INP, 4'h7},
      '{3'h5, 8'h80, DRV, NO}, '{3'h5, 8'h40, OD, 4'h1}, '{3'h5, 8'h20, OD, 4'h3},
      '{3'h5, 8'h08, DRV, 4'h6}, '{3'h5, 8'h02, INP, 4'hD}, '{3'h6, 8'h80, DRV, NO},
      '{3'h6, 8'h40, OD, 4'h0}, '{3'h6, 8'h20, OD, 4'h2}, '{3'h6, 8'h08, INP, 4'h7},
      '{3'h6, 8'h04, INP, 4'hE}};

   logic clk, srst, wb_cyc, wb_stb, wb_we, wb_ack, lv;
   logic [ADR_W-1:0] wb_adr;
   logic [3:0] wb_sel, i2c_pull;
   logic [31:0] wb_wdat, wb_rdat;
   logic [NUM_PINS-1:0] pad_lvl, pad_o, pad_oe, ext_val, ext_oe, gpio_oe, gpio_in, irq_a, irq_b;
   logic [PWM_CHANNELS-1:0] pwm;
   logic [11:0] in_vec;
   int err_count, comparisons;

   pfs_pin_mux i_dut (.clk_i(clk), .srst_i(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pad_i(pad_lvl), .pad_o(pad_o), .pad_oe_o(pad_oe),
      .pwm_i(pwm), .buzzer_i(lv), .i2c_m_scl_pull_i(i2c_pull[0]), .i2c_m_sda_pull_i(i2c_pull[1]),
      .i2c_s2_scl_pull_i(i2c_pull[2]), .i2c_s2_sda_pull_i(i2c_pull[3]),
      .i2c_m_scl_in_o(in_vec[0]), .i2c_m_sda_in_o(in_vec[1]), .i2c_s2_scl_in_o(in_vec[2]),
      .i2c_s2_sda_in_o(in_vec[3]), .spi_sck_out_i(lv), .spi_sck_oe_i(1'b1), .spi_so_out_i(lv),
      .spi_so_oe_i(1'b1), .spi_mo_out_i(lv), .spi_mo_oe_i(1'b1), .spi_sck_in_o(in_vec[4]),
      .spi_so_in_o(in_vec[5]), .spi_mo_in_o(in_vec[6]), .spi_select_n_o(in_vec[7]),
      .uart_two_txd_i(lv), .uart_zero_txd_i(lv), .uart_two_rxd_o(in_vec[8]),
      .uart_zero_rxd_o(in_vec[9]), .cap_out_i({lv, lv}), .cap_oe_i(2'h3),
      .cap_in_o(in_vec[11:10]), .irq_a_pins_o(irq_a), .irq_b_pins_o(irq_b),
      .gpio_out_i({NUM_PINS{lv}}), .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in));

   pfs_far_side i_far (.pad_out_i(pad_o), .pad_oe_i(pad_oe), .ext_val_i(ext_val),
      .ext_oe_i(ext_oe), .pad_lvl_o(pad_lvl));

   // 250 MHz
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // classic cycle: hold everything until ack is sampled, then release
   task automatic wb_xfer(input logic we, input logic [15:0] idx, input logic [7:0] dat,
                          input logic [3:0] sel, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_sel <= sel;
      wb_adr <= {idx, 2'h0};
      wb_wdat <= {24'h0, dat};
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rd = wb_rdat;
      if (n >= 50) check(32'h0, 32'h1, "no bus answer");
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] dat, input logic [3:0] sel);
      logic [31:0] d;
      wb_xfer(1'b1, idx, dat, sel, d);
   endtask

   task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      wb_xfer(1'b0, idx, 8'h00, 4'hF, d);
      check(d, {24'h0, exp}, "register read");
   endtask

   // both levels through one route, every source at the level under test except the other pwm channels and the i2c pulls, which take the opposite level
   task automatic run_row(input pfs_row_type r);
      logic [14:0] full;
      logic [15:0] idx;
      idx = REG_FIRST_IDX + {13'h0, r.pin};
      wr(idx, r.cfg, 4'hF);
      for (int v = 0; v < 2; v++) begin
         @(posedge clk);
         lv <= v[0];
         pwm <= v[0] ? (12'h001 << PIN_PWM_CH[r.pin]) : ~(12'h001 << PIN_PWM_CH[r.pin]);
         i2c_pull <= {4{~v[0]}};
         gpio_oe <= {NUM_PINS{r.kind == DRV}};
         ext_val <= {NUM_PINS{v[0]}};
         ext_oe <= (r.kind == INP) ? (7'h01 << r.pin) : 7'h00;
         repeat (5) @(posedge clk);
         full = {irq_b[r.pin], irq_a[r.pin], gpio_in[r.pin], in_vec};
         if (r.kind != INP) check(pad_o[r.pin], (r.kind == DRV) ? v[0] : 1'b0, "pad value");
         check(pad_oe[r.pin], (r.kind == DRV) || (r.kind == OD && !v[0]), "pad enable");
         if (r.idx != NO) check(full[r.idx], v[0], "routed input");
      end
      wr(idx, CFG_RESET, 4'hF);
   endtask

   // hang guard, far beyond the roughly eight hundred cycles the tests need
   initial begin
      #80000;
      err_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_of_test();
   end

   initial begin
      srst = 1'b1;
      {wb_cyc, wb_stb, wb_we, lv} = 4'h0;
      wb_adr = '0;
      wb_sel = 4'h0;
      wb_wdat = 32'h0;
      pwm = '0;
      i2c_pull = 4'h0;
      gpio_oe = '0;
      ext_val = '1;
      ext_oe = '1;
      err_count = 0;
      comparisons = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      // reset state: nothing selected, plain io off
      for (int p = 0; p < NUM_PINS; p++) rd_chk(REG_FIRST_IDX + 16'(p), CFG_RESET);
      check(pad_oe, 7'h00, "pads after reset");
      check(gpio_in, 7'h00, "plain io after reset");
      $display("test reset_state done");
      foreach (ROWS[i]) run_row(ROWS[i]);
      $display("test route_rows done");
      // full write, bit 4 exists only on three pins
      for (int p = 0; p < NUM_PINS; p++) begin
         wr(REG_FIRST_IDX + 16'(p), CFG_ALL_BITS, 4'hF);
         rd_chk(REG_FIRST_IDX + 16'(p), PINS_FN4[p] ? CFG_ALL_BITS : CFG_NO_FN4);
         wr(REG_FIRST_IDX + 16'(p), CFG_RESET, 4'hF);
      end
      $display("test read_back done");
      // refused writes and unmapped places
      wr(REG_FIRST_IDX, 8'hA5, 4'hE);
      rd_chk(REG_FIRST_IDX, CFG_RESET);
      wr(REG_FIRST_IDX - 16'h1, 8'h5A, 4'hF);
      wr(REG_LAST_IDX + 16'h1, 8'h5A, 4'hF);
      rd_chk(REG_FIRST_IDX - 16'h1, 8'h00);
      rd_chk(REG_LAST_IDX, CFG_RESET);
      $display("test refused done");
      // one pin in both shared sources, two pins in one
      wr(REG_FIRST_IDX, 8'h06, 4'hF);
      wr(REG_LAST_IDX, 8'h02, 4'hF);
      ext_val <= 7'h41;
      ext_oe <= '1; // drive every pad, a pull-up would hide the low level
      repeat (5) @(posedge clk);
      check(irq_a, 7'h41, "irq a pins");
      check(irq_b, 7'h01, "irq b pins");
      ext_val <= 7'h00;
      repeat (5) @(posedge clk);
      check({irq_a, irq_b}, 14'h0, "irq pins low");
      $display("test shared_irq done");
      // reset in mid-run clears a live route
      wr(REG_FIRST_IDX + 16'h2, 8'h80, 4'hF);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rd_chk(REG_FIRST_IDX, CFG_RESET);
      rd_chk(REG_FIRST_IDX + 16'h2, CFG_RESET);
      check(pad_oe, 7'h00, "pads after second reset");
      $display("test mid_reset done");
      end_of_test();
   end
endmodule
